// ===== include/ipms_defines.vh
`ifndef IPMS_DEFINES_VH
`define IPMS_DEFINES_VH

// clock and time base
`define IPMS_CLK_KHZ        50000
`define IPMS_TICK_MS        1
`define IPMS_TICK_CYCLES    (`IPMS_CLK_KHZ * `IPMS_TICK_MS)

// register byte offsets (word aligned)
`define IPMS_REG_CTRL       8'h00
`define IPMS_REG_POL        8'h04
`define IPMS_REG_FUNC_LO    8'h08
`define IPMS_REG_FUNC_HI    8'h0c
`define IPMS_REG_SETTLE     8'h10
`define IPMS_REG_SPZERO     8'h14
`define IPMS_REG_STATUS     8'h18
`define IPMS_REG_FREQ       8'h1c
`define IPMS_REG_PRESET0    8'h40
`define IPMS_REG_PRESET15   8'h7c

// control register fields
`define IPMS_CTRL_MODE_LSB  0
`define IPMS_CTRL_MODE_MSB  1
`define IPMS_CTRL_SRC_LSB   2
`define IPMS_CTRL_SRC_MSB   3
`define IPMS_CTRL_REV_BIT   4
`define IPMS_CTRL_RESET     32'h0000_0000

// speed mode and frequency source encodings
`define IPMS_MODE_BINARY    2'h0
`define IPMS_MODE_BIT       2'h1
`define IPMS_SRC_OPERATOR   2'h0
`define IPMS_SRC_TERMINAL   2'h1

// polarity encodings, two bits per terminal
`define IPMS_POL_NO         2'h0
`define IPMS_POL_NC         2'h1
`define IPMS_POL_RESET      18'h0_0000

// terminal function codes
`define IPMS_FN_BIN0        8'h02
`define IPMS_FN_BIN3        8'h05
`define IPMS_FN_FAULTCLR    8'h12
`define IPMS_FN_ONEHOT1     8'h20
`define IPMS_FN_ONEHOT7     8'h26
`define IPMS_FN_GP1         8'h38
`define IPMS_FN_GP8         8'h3f
`define IPMS_FN_NONE        8'hff
`define IPMS_FUNC_RESET     64'hffff_ffff_ffff_ffff

// field widths and resets
`define IPMS_SETTLE_W       8
`define IPMS_SETTLE_RESET   8'h00
`define IPMS_FREQ_W         16
`define IPMS_FREQ_RESET     16'h0000

// AXI4-Lite responses
`define IPMS_RESP_OKAY      2'h0
`define IPMS_RESP_SLVERR    2'h2

`endif

// ===== src/ipms_settle.v
`timescale 1ns/1ps
`include "ipms_defines.vh"

// holds a 4-bit select value until it has stayed unchanged for a whole delay
module ipms_settle (
    // clock and reset
    input  wire                      sys_clk,
    input  wire                      arst_n,
    // time base and delay in ticks
    input  wire                      tick,
    input  wire [`IPMS_SETTLE_W-1:0] delay,
    // raw and accepted select
    input  wire [3:0]                rawSel,
    output reg  [3:0]                settledSel
);

    reg [3:0]                lastSel;   // value seen on the previous cycle
    reg [`IPMS_SETTLE_W-1:0] elapsed;   // ticks since the last change

    // any change restarts the wait, so a chattering contact never lands
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lastSel    <= 4'h0;
            elapsed    <= `IPMS_SETTLE_RESET;
            settledSel <= 4'h0;
        end else begin
            lastSel <= rawSel;
            if (rawSel != lastSel) begin
                elapsed <= `IPMS_SETTLE_RESET;
            end else if (elapsed >= delay) begin
                settledSel <= lastSel;
            end else if (tick) begin
                elapsed <= elapsed + 1'b1;
            end
        end
    end

endmodule

// ===== src/ipms_top.v
// Function
// - NO setting: closed contact means asserted
// - NC setting: open contact means asserted
// - fault-clear terminal always normally open
// - mode 00 binary sixteen, 01 one-hot eight
// - codes 02..05 assign binary select bits
// - binary index: first select is LSB
// - index 1..15 picks stored preset
// - speed 0 uses main frequency source
// - binary index accepted after settle delay
// - codes 32..38 assign one-hot selects
// - one-hot select n picks speed n
// - lowest terminal wins among several selects
// - negative main plus aux reverses direction
// - codes 56..63 feed sequence program inputs
// - duplicate function kept only on last-written terminal
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ipms_defines.vh"

module ipms_top #(
    parameter TICK_CYCLES = `IPMS_TICK_CYCLES    // 1 ms time base
) (
    // clock and reset
    input  wire                           sys_clk,
    input  wire                           arst_n,
    // contact inputs, high while the contact is closed
    input  wire [7:0]                     terminalRaw,
    input  wire                           forwardRunRaw,
    // analog frequency commands, signed
    input  wire signed [`IPMS_FREQ_W-1:0] mainAnalogFreq,
    input  wire signed [`IPMS_FREQ_W-1:0] auxAnalogFreq,
    // AXI4-Lite write address
    input  wire [7:0]                     s_axi_awaddr,
    input  wire                           s_axi_awvalid,
    output reg                            s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]                    s_axi_wdata,
    input  wire [3:0]                     s_axi_wstrb,
    input  wire                           s_axi_wvalid,
    output reg                            s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]                     s_axi_bresp,
    output reg                            s_axi_bvalid,
    input  wire                           s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]                     s_axi_araddr,
    input  wire                           s_axi_arvalid,
    output reg                            s_axi_arready,
    output reg  [31:0]                    s_axi_rdata,
    output reg  [1:0]                     s_axi_rresp,
    output reg                            s_axi_rvalid,
    input  wire                           s_axi_rready,
    // decoded results
    output reg  [3:0]                     speedIndex,
    output reg  [`IPMS_FREQ_W-1:0]        freqCommand,
    output reg                            runForward,
    output reg                            runReverse,
    output reg                            fault_clear_input,
    output reg  [7:0]                     gpSequenceInputs
);

    // configuration state
    reg [31:0]               ctrlReg;                 // mode, source, reversible
    reg [17:0]               polarityCfg;             // terminal_polarity_cfg + forward_polarity_cfg
    reg [63:0]               terminal_function_cfg;   // one code byte per terminal
    reg [`IPMS_SETTLE_W-1:0] select_settle_delay;     // in time-base ticks
    reg [`IPMS_FREQ_W-1:0]   speed_zero_setpoint;     // operator set-point
    reg [`IPMS_FREQ_W-1:0]   preset_freq_table [0:15]; // entry 0 unused

    // synchroniser stages
    reg [8:0] syncMeta;    // first stage, read only by syncStable
    reg [8:0] syncStable;  // second stage

    // time base
    reg [31:0] tickCount;
    reg        tick;

    // write channel capture
    reg [7:0]  wrAddr;
    reg        wrAddrHeld;
    reg [31:0] wrData;
    reg [3:0]  wrStrb;
    reg        wrDataHeld;

    // decode helpers
    integer                  i;              // each process keeps loop indices of its own
    integer                  j;
    integer                  p;
    integer                  k;
    integer                  m;
    reg [7:0]                asserted;       // per terminal after polarity
    reg [3:0]                binSel;
    reg [7:0]                gpSel;
    reg                      faultClr;
    reg [7:0]                oneHotCode;     // speed number before narrowing
    reg [2:0]                oneHotIndex;
    reg [3:0]                next_speed;
    reg signed [`IPMS_FREQ_W:0] analogSum;
    reg [`IPMS_FREQ_W:0]     analogMag;      // magnitude of the analog sum
    reg [63:0]               next_func;
    wire [3:0]               settledBin;
    wire [1:0]               speedMode = ctrlReg[`IPMS_CTRL_MODE_MSB:`IPMS_CTRL_MODE_LSB];
    wire [1:0]               freqSource = ctrlReg[`IPMS_CTRL_SRC_MSB:`IPMS_CTRL_SRC_LSB];
    wire                     wrFire = wrAddrHeld && wrDataHeld && !s_axi_bvalid;

    // returns the function code held for one terminal
    function [7:0] funcOf;
        input [63:0] cfg;
        input integer idx;
        begin
            funcOf = cfg[idx*8 +: 8];
        end
    endfunction

    // true when an offset falls inside the preset table window
    function isPreset;
        input [7:0] addr;
        begin
            isPreset = (addr >= `IPMS_REG_PRESET0) && (addr <= `IPMS_REG_PRESET15) && (addr[1:0] == 2'h0);
        end
    endfunction

    // two-flop synchroniser for every contact input
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncMeta   <= 9'h000;
            syncStable <= 9'h000;
        end else begin
            syncMeta   <= {forwardRunRaw, terminalRaw};
            syncStable <= syncMeta;
        end
    end

    // divider giving a one-cycle tick per time-base period
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tickCount <= 32'h0000_0000;
            tick      <= 1'b0;
        end else if (tickCount >= TICK_CYCLES - 1) begin
            tickCount <= 32'h0000_0000;
            tick      <= 1'b1;
        end else begin
            tickCount <= tickCount + 32'h0000_0001;
            tick      <= 1'b0;
        end
    end

    // polarity correction and function gathering
    always @* begin
        binSel    = 4'h0;
        gpSel     = 8'h00;
        faultClr  = 1'b0;
        asserted  = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (funcOf(terminal_function_cfg, i) == `IPMS_FN_FAULTCLR) begin
                asserted[i] = syncStable[i];
            end else if (polarityCfg[i*2 +: 2] == `IPMS_POL_NC) begin
                asserted[i] = !syncStable[i];
            end else begin
                asserted[i] = syncStable[i];
            end
            for (j = 0; j < 4; j = j + 1) begin
                if (funcOf(terminal_function_cfg, i) == `IPMS_FN_BIN0 + j) begin
                    binSel[j] = binSel[j] | asserted[i];
                end
            end
            for (j = 0; j < 8; j = j + 1) begin
                if (funcOf(terminal_function_cfg, i) == `IPMS_FN_GP1 + j) begin
                    gpSel[j] = gpSel[j] | asserted[i];
                end
            end
            if (funcOf(terminal_function_cfg, i) == `IPMS_FN_FAULTCLR) begin
                faultClr = asserted[i];
            end
        end
    end

    // binary select must settle before it is taken
    ipms_settle u_settle (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .tick       (tick),
        .delay      (select_settle_delay),
        .rawSel     (binSel),
        .settledSel (settledBin)
    );

    // one-hot priority: scan downward so the lowest terminal is applied last
    always @* begin
        oneHotIndex = 3'h0;
        oneHotCode  = 8'h00;
        for (p = 7; p >= 0; p = p - 1) begin
            if (asserted[p] && funcOf(terminal_function_cfg, p) >= `IPMS_FN_ONEHOT1 &&
                funcOf(terminal_function_cfg, p) <= `IPMS_FN_ONEHOT7) begin
                oneHotCode  = funcOf(terminal_function_cfg, p) - `IPMS_FN_ONEHOT1 + 8'h01;
                oneHotIndex = oneHotCode[2:0];
            end
        end
        if (speedMode == `IPMS_MODE_BIT) begin
            next_speed = {1'b0, oneHotIndex};
        end else begin
            next_speed = settledBin;
        end
        analogSum = mainAnalogFreq + auxAnalogFreq;
        analogMag = analogSum[`IPMS_FREQ_W] ? -analogSum : analogSum;
    end

    // speed, frequency and direction outputs, all registered
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            speedIndex        <= 4'h0;
            freqCommand       <= `IPMS_FREQ_RESET;
            runForward        <= 1'b0;
            runReverse        <= 1'b0;
            fault_clear_input <= 1'b0;
            gpSequenceInputs  <= 8'h00;
        end else begin
            speedIndex        <= next_speed;
            fault_clear_input <= faultClr;
            gpSequenceInputs  <= gpSel;
            if (next_speed != 4'h0) begin
                freqCommand <= preset_freq_table[next_speed];
            end else if (freqSource == `IPMS_SRC_OPERATOR) begin
                freqCommand <= speed_zero_setpoint;
            end else begin
                freqCommand <= analogMag[`IPMS_FREQ_W-1:0];
            end
            // forward run after its own polarity, possibly turned round
            if ((syncStable[8] ^ (polarityCfg[17:16] == `IPMS_POL_NC)) &&
                freqSource == `IPMS_SRC_TERMINAL && ctrlReg[`IPMS_CTRL_REV_BIT] && analogSum < 0) begin
                runForward <= 1'b0;
                runReverse <= 1'b1;
            end else begin
                runForward <= syncStable[8] ^ (polarityCfg[17:16] == `IPMS_POL_NC);
                runReverse <= 1'b0;
            end
        end
    end

    // function table update; a written terminal takes its code from every other terminal
    always @* begin
        next_func = terminal_function_cfg;
        for (k = 0; k < 8; k = k + 1) begin
            if (wrStrb[k % 4] && ((k < 4) ? (wrAddr == `IPMS_REG_FUNC_LO) : (wrAddr == `IPMS_REG_FUNC_HI))) begin
                next_func[k*8 +: 8] = wrData[(k % 4)*8 +: 8];
                for (m = 0; m < 8; m = m + 1) begin
                    if (m != k && next_func[m*8 +: 8] == next_func[k*8 +: 8] &&
                        next_func[k*8 +: 8] != `IPMS_FN_NONE) begin
                        next_func[m*8 +: 8] = `IPMS_FN_NONE;
                    end
                end
            end
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready         <= 1'b0;
            s_axi_wready          <= 1'b0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `IPMS_RESP_OKAY;
            wrAddr                <= 8'h00;
            wrAddrHeld            <= 1'b0;
            wrData                <= 32'h0000_0000;
            wrStrb                <= 4'h0;
            wrDataHeld            <= 1'b0;
            ctrlReg               <= `IPMS_CTRL_RESET;
            polarityCfg           <= `IPMS_POL_RESET;
            terminal_function_cfg <= `IPMS_FUNC_RESET;
            select_settle_delay   <= `IPMS_SETTLE_RESET;
            speed_zero_setpoint   <= `IPMS_FREQ_RESET;
        end else begin
            s_axi_awready <= !wrAddrHeld && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wrDataHeld && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddr     <= s_axi_awaddr;
                wrAddrHeld <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wrData     <= s_axi_wdata;
                wrStrb     <= s_axi_wstrb;
                wrDataHeld <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wrFire) begin
                wrAddrHeld   <= 1'b0;
                wrDataHeld   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `IPMS_RESP_OKAY;
                terminal_function_cfg <= next_func;
                case (wrAddr)
                    `IPMS_REG_CTRL: begin
                        if (wrStrb[0]) ctrlReg[7:0] <= wrData[7:0];
                    end
                    `IPMS_REG_POL: begin
                        if (wrStrb[0]) polarityCfg[7:0] <= wrData[7:0];
                        if (wrStrb[1]) polarityCfg[15:8] <= wrData[15:8];
                        if (wrStrb[2]) polarityCfg[17:16] <= wrData[17:16];
                    end
                    `IPMS_REG_FUNC_LO, `IPMS_REG_FUNC_HI: begin
                    end
                    `IPMS_REG_SETTLE: begin
                        if (wrStrb[0]) select_settle_delay <= wrData[`IPMS_SETTLE_W-1:0];
                    end
                    `IPMS_REG_SPZERO: begin
                        if (wrStrb[0]) speed_zero_setpoint[7:0] <= wrData[7:0];
                        if (wrStrb[1]) speed_zero_setpoint[15:8] <= wrData[15:8];
                    end
                    default: begin
                        if (!isPreset(wrAddr) || wrAddr == `IPMS_REG_PRESET0) begin
                            s_axi_bresp <= `IPMS_RESP_SLVERR;   // unmapped or read-only
                        end
                    end
                endcase
            end
        end
    end

    // preset table lives in an array without reset; speed 0 entry is never written
    always @(posedge sys_clk) begin
        if (wrFire && isPreset(wrAddr) && wrAddr != `IPMS_REG_PRESET0) begin
            if (wrStrb[0]) preset_freq_table[wrAddr[5:2]][7:0] <= wrData[7:0];
            if (wrStrb[1]) preset_freq_table[wrAddr[5:2]][15:8] <= wrData[15:8];
        end
    end

    // AXI4-Lite read path: one read at a time, answer two edges after the request
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `IPMS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `IPMS_RESP_OKAY;
                case (s_axi_araddr)
                    `IPMS_REG_CTRL:    s_axi_rdata <= ctrlReg;
                    `IPMS_REG_POL:     s_axi_rdata <= {14'h0000, polarityCfg};
                    `IPMS_REG_FUNC_LO: s_axi_rdata <= terminal_function_cfg[31:0];
                    `IPMS_REG_FUNC_HI: s_axi_rdata <= terminal_function_cfg[63:32];
                    `IPMS_REG_SETTLE:  s_axi_rdata <= {24'h00_0000, select_settle_delay};
                    `IPMS_REG_SPZERO:  s_axi_rdata <= {16'h0000, speed_zero_setpoint};
                    `IPMS_REG_STATUS:  s_axi_rdata <= {4'h0, gpSequenceInputs, runReverse, runForward,
                                                       fault_clear_input, syncStable[8],
                                                       asserted, 4'h0, speedIndex};
                    `IPMS_REG_FREQ:    s_axi_rdata <= {16'h0000, freqCommand};
                    default: begin
                        if (isPreset(s_axi_araddr) && s_axi_araddr != `IPMS_REG_PRESET0) begin
                            s_axi_rdata <= {16'h0000, preset_freq_table[s_axi_araddr[5:2]]};
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= `IPMS_RESP_SLVERR;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ===== verification/ipms_contacts.sv
`timescale 1ns/1ps
// external contacts; with bounce set a terminal contact chatters after each change, the forward run contact never
module ipms_contacts (
    // clock
    input logic        sys_clk,
    // wanted contact states and chatter enable
    input logic [7:0]  closeReq,
    input logic        fwdReq,
    input logic        bounce,
    // contact lines
    output logic [7:0] terminalRaw,
    output logic       forwardRunRaw
);
    logic [7:0] lastReq; // request of last cycle
    logic [2:0] chatter; // chatter cycles left
    initial begin
        lastReq = 8'h00;
        chatter = 3'h0;
        terminalRaw = 8'h00;
        forwardRunRaw = 1'b0;
    end
    // lines move just after the edge, never in step with the sampler
    always @(posedge sys_clk) begin
        lastReq <= closeReq;
        forwardRunRaw <= fwdReq;
        if (closeReq != lastReq) begin
            chatter <= bounce ? 3'h7 : 3'h0;
        end else if (chatter != 3'h0) begin
            chatter <= chatter - 3'h1;
        end
        // odd counts show the inverse, so the sampler sees real fluctuation
        terminalRaw <= chatter[0] ? ~closeReq : closeReq;
    end
endmodule

// ===== verification/ipms_props.sv
`timescale 1ns/1ps
// watches bus handshakes and decode timing at the top ports
module ipms_props (
    // clock and reset
    input logic        sys_clk,
    input logic        arst_n,
    // contacts and bus handshakes
    input logic [7:0]  terminalRaw,
    input logic        s_axi_awready,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // decoded outputs
    input logic [3:0]  speedIndex,
    input logic        runForward,
    input logic        runReverse,
    input logic        fault_clear_input,
    input logic [7:0]  gpSequenceInputs
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] termQ; // contacts one cycle back
    logic [5:0] cause; // recent contact change or register write
    // a decoded level may only move shortly after something caused it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            termQ <= 8'h00;
            cause <= 6'h3f;
        end else begin
            termQ <= terminalRaw;
            cause <= {cause[4:0], s_axi_bvalid || terminalRaw != termQ};
        end
    end
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
    b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
    r_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not closed");
    r_answer_a: assert property (rdTaken |=> s_axi_rvalid) else $error("read not answered");
    dir_excl_a: assert property (!(runForward && runReverse)) else $error("both directions");
    reset_zero_a: assert property ($rose(arst_n) |-> speedIndex == 4'h0 && !runForward) else $error("reset");
    gp_cause_a: assert property ($changed(gpSequenceInputs) |-> |cause) else $error("gp moved");
    fc_cause_a: assert property ($changed(fault_clear_input) |-> |cause) else $error("clear moved");
endmodule

// ===== verification/test_input_polarity_multispeed_select.sv
`timescale 1ns/1ps
module test_input_polarity_multispeed_select;
    logic sys_clk, arst_n, fwdReq, bounce, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] closeReq, awaddr, araddr;
    logic [31:0] wdata;
    logic [15:0] mainFreq, auxFreq;
    wire [7:0] terminalRaw, gp;
    wire forwardRunRaw, awready, wready, bvalid, arready, rvalid, runFwd, runRev, faultClr;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] idx;
    wire [15:0] freq;
    int errTotal, totalChecks;
    // rows: mode, contacts, speed, frequency, gp inputs
    logic [36:0] rows [9] = '{{1'b0, 8'h01, 4'h1, 16'h0101, 8'h00}, {1'b0, 8'h0a, 4'ha, 16'h010a, 8'h00},
        {1'b0, 8'h0f, 4'hf, 16'h010f, 8'h00}, {1'b0, 8'hc8, 4'h8, 16'h0108, 8'h06},
        {1'b0, 8'h00, 4'h0, 16'h0777, 8'h00}, {1'b1, 8'h24, 4'h3, 16'h0103, 8'h00},
        {1'b1, 8'h40, 4'h7, 16'h0107, 8'h00}, {1'b1, 8'h7f, 4'h1, 16'h0101, 8'h00},
        {1'b1, 8'h80, 4'h0, 16'h0777, 8'h01}};
    ipms_contacts ipms_contacts_i (.sys_clk, .closeReq, .fwdReq, .bounce, .terminalRaw, .forwardRunRaw);
    // short tick keeps settle delays to a few cycles
    ipms_top #(.TICK_CYCLES(4)) ipms_top_i (.sys_clk, .arst_n, .terminalRaw, .forwardRunRaw,
        .mainAnalogFreq(mainFreq), .auxAnalogFreq(auxFreq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .speedIndex(idx),
        .freqCommand(freq), .runForward(runFwd), .runReverse(runRev), .fault_clear_input(faultClr),
        .gpSequenceInputs(gp));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a hung handshake ends the run
    task automatic limit(input int n);
        if (n >= 40) begin
            errTotal++;
            tally_and_finish();
        end
    endtask
    // one write; bready goes up with the request and stays until bvalid is seen
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge sys_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        limit(n);
        chk(bresp, er);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge sys_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        rready <= 1'b0;
        limit(n);
        chk(rdata, ed);
        chk(rresp, er);
    endtask
    task automatic cfg(input logic bitMode);
        axw(8'h00, {31'h0, bitMode}, 2'h0);
        axw(8'h08, bitMode ? 32'h23222120 : 32'h05040302, 2'h0);
        axw(8'h0c, bitMode ? 32'h38262524 : 32'h3a393812, 2'h0);
    endtask
    task automatic drive(input logic [7:0] t, input int c);
        closeReq <= t;
        repeat (c) @(posedge sys_clk);
    endtask
    initial begin
        arst_n = 1'b0;
        {closeReq, fwdReq, bounce, mainFreq, auxFreq} = '0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        chk(idx, 4'h0);
        axr(8'h08, 32'hffffffff, 2'h0);
        axr(8'h04, 32'h0, 2'h0);
        axr(8'h40, 32'h0, 2'h2);
        axr(8'h20, 32'h0, 2'h2);
        axw(8'h18, 32'h1, 2'h2);
        for (int n = 1; n < 16; n++) axw(8'h40 + 8'(4 * n), 32'h0100 + 32'(n), 2'h0);
        axw(8'h14, 32'h0777, 2'h0);
        for (int i = 0; i < 9; i++) begin
            if (i == 0 || i == 5) cfg(rows[i][36]);
            drive(rows[i][35:28], 10);
            chk(idx, rows[i][27:24]);
            chk(freq, rows[i][23:8]);
            chk(gp, rows[i][7:0]);
        end
        // a code taken twice stays only where written last
        axw(8'h0c, 32'h20262524, 2'h0);
        axr(8'h08, 32'h232221ff, 2'h0);
        drive(8'h80, 10);
        chk(idx, 4'h1);
        // inverted terminals, fault clear must ignore its inversion
        cfg(1'b0);
        axw(8'h04, 32'h0501, 2'h0);
        drive(8'h00, 10);
        chk({idx, gp, faultClr}, {4'h1, 8'h01, 1'b0});
        drive(8'h11, 10);
        chk({idx, faultClr}, {4'h0, 1'b1});
        axw(8'h04, 32'h0, 2'h0);
        // chattering select must not be taken before it settles
        axw(8'h10, 32'h3, 2'h0);
        bounce <= 1'b1;
        drive(8'h00, 30);
        drive(8'h03, 10);
        chk(idx, 4'h0);
        drive(8'h03, 40);
        chk(idx, 4'h3);
        bounce <= 1'b0;
        axw(8'h10, 32'h0, 2'h0);
        axw(8'h00, 32'h14, 2'h0);
        {fwdReq, mainFreq, auxFreq} <= {1'b1, 16'hff9c, 16'h0014};
        drive(8'h00, 10);
        chk({runFwd, runRev, freq}, {2'b01, 16'h0050});
        mainFreq <= 16'h0064;
        drive(8'h00, 10);
        chk({runFwd, runRev, freq}, {2'b10, 16'h0078});
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({idx, runFwd, freq}, 21'h0);
        arst_n <= 1'b1;
        axr(8'h00, 32'h0, 2'h0);
        tally_and_finish();
    end
endmodule
bind ipms_top ipms_props ipms_props_i (.sys_clk, .arst_n, .terminalRaw, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .speedIndex, .runForward, .runReverse, .fault_clear_input, .gpSequenceInputs);
